// [gpps_defines.vh]
// constants for the shared-pin port block
// Functional notes
// - each six-bit port pin is set and read on its own
// - every pin driver selectable open-drain or push-pull by software bit
// - six-bit port input read as skip decision on a selected bit
// - six-bit port bits 2 and 3 have switchable pull-up and wakeup
// - nibble port a is 4-bit I/O with per-bit driver type
// - nibble port a has switchable pull-up and key-on wakeup
// - nibble port b is 4-bit with pull-up, wakeup, driver type
// - pair port a is 2-bit with pull-up, wakeup, driver type
// - pair port b is 2-bit with per-bit driver type
// - nibble a bits 0,1,2 shared with serial in, out, clock
// - nibble b bits 1,2,3 shared with counter one, zero, irq
// - analog inputs 0..5 on pair a, pair b, six-bit bits 2,3
// - counter pin zero clocks timer 2, outputs timer 1 PWM
// - counter pin one clocks timer 1, outputs timer 2 PWM
// - irq pin takes interrupts, with switchable key-on wakeup
// - nibble a bit 0 stays full I/O during serial input use
// - nibble a bit 1 input still reads pin under serial output
// - nibble a bit 2 input still reads pin under serial clock
// - nibble b bit 1 readable as counter out, full I/O as counter in
// - nibble b bit 2 readable as counter out, full I/O as counter in
// - nibble b bit 3 stays full I/O during irq use
// - analog-shared bits remain digital I/O while analog is used
// - any reset source drives the open-drain reset pin low
`ifndef GPPS_DEFINES_VH
`define GPPS_DEFINES_VH
`define GPPS_SIX_W 6
`define GPPS_NIB_W 4
`define GPPS_PAIR_W 2
`define GPPS_LATCH_RST 1'b1
`define GPPS_CFG_RST 1'b0
`define GPPS_SER_IN_BIT 0
`define GPPS_SER_OUT_BIT 1
`define GPPS_SER_CLK_BIT 2
`define GPPS_CNT1_BIT 1
`define GPPS_CNT0_BIT 2
`define GPPS_IRQ_BIT 3
`define GPPS_SIX_KEY_LO 2
`define GPPS_SIX_KEY_HI 3
`define GPPS_AN_W 6
`endif

// [gpps_pin_cell.v]
// one port bit: output latch, driver type, pull-up and wakeup enables
`timescale 1ns/1ps
`include "gpps_defines.vh"
module gpps_pin_cell #(
    parameter HAS_PULL = 1
) (
    clk,
    rstSync_b,
    latchWe,
    latchWd,
    cfgWe,
    pushPullWd,
    pullWd,
    wakeWd,
    altOutEn,
    altOut,
    pinIn,
    pinOut,
    pinOe_b,
    pullOn,
    wakeEn,
    wakeHit
);
    input wire clk;
    input wire rstSync_b;
    input wire latchWe;
    input wire latchWd;
    input wire cfgWe;
    input wire pushPullWd;
    input wire pullWd;
    input wire wakeWd;
    input wire altOutEn;
    input wire altOut;
    input wire pinIn;
    output reg pinOut;
    output wire pinOe_b;
    output reg pullOn;
    output wire wakeEn;
    output wire wakeHit;

    reg latch_ff;
    reg pushPull_ff;
    reg pull_ff;
    reg wake_ff;
    wire drvLevel;

    always @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            latch_ff <= `GPPS_LATCH_RST;
            pushPull_ff <= `GPPS_CFG_RST;
            pull_ff <= `GPPS_CFG_RST;
            wake_ff <= `GPPS_CFG_RST;
        end else begin
            if (latchWe) begin
                latch_ff <= latchWd;
            end
            if (cfgWe) begin
                pushPull_ff <= pushPullWd;
                pull_ff <= (HAS_PULL != 0) & pullWd;
                wake_ff <= (HAS_PULL != 0) & wakeWd;
            end
        end
    end

    // alternate function output is ANDed with the latch, so keep latch 1
    assign drvLevel = altOutEn ? (altOut & latch_ff) : latch_ff;

    always @* begin
        pinOut = drvLevel;
        pullOn = pull_ff;
    end

    // open-drain: drive only a low; push-pull: drive always
    assign pinOe_b = ~(pushPull_ff | ~drvLevel);
    assign wakeEn = wake_ff;
    // wakeup on low pin level whenever enabled, whatever the latch holds
    assign wakeHit = wake_ff & ~pinIn;
endmodule

// [gpps_reset_pin.v]
// open-drain reset pin driver and reset release synchroniser
`timescale 1ns/1ps
`include "gpps_defines.vh"
module gpps_reset_pin (
    clk,
    rst_b,
    swResetReq,
    wdtResetReq,
    vdropResetReq,
    porResetReq,
    rstSync_b,
    resetPinOut,
    resetPinOe_b
);
    input wire clk;
    input wire rst_b;
    input wire swResetReq;
    input wire wdtResetReq;
    input wire vdropResetReq;
    input wire porResetReq;
    output wire rstSync_b;
    output wire resetPinOut;
    output wire resetPinOe_b;

    reg sync1_ff;
    reg sync2_ff;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= 1'b1;
            sync2_ff <= sync1_ff;
        end
    end

    assign rstSync_b = sync2_ff;
    assign resetPinOut = 1'b0;
    // open-drain: enable low pulls pin low on any reset source
    assign resetPinOe_b = ~(swResetReq | wdtResetReq | vdropResetReq |
        porResetReq | ~sync2_ff);
endmodule

// [gpps_top.v]
// shared-pin general-purpose ports: six-bit, two nibble, two pair ports
`timescale 1ns/1ps
`include "gpps_defines.vh"
module gpps_top #(
    parameter SIX_W = `GPPS_SIX_W,
    parameter NIB_W = `GPPS_NIB_W,
    parameter PAIR_W = `GPPS_PAIR_W
) (
    clk,
    rst_b,
    swResetReq,
    wdtResetReq,
    vdropResetReq,
    porResetReq,
    resetPinOut,
    resetPinOe_b,
    sixBitSetStb,
    sixBitClrStb,
    sixBitSel,
    sixBitCfgWe,
    sixBitPushPull,
    sixBitPull,
    sixBitWake,
    sixBitSkip,
    nibAWe,
    nibAWd,
    nibACfgWe,
    nibAPushPull,
    nibAPull,
    nibAWake,
    nibARd,
    nibBWe,
    nibBWd,
    nibBCfgWe,
    nibBPushPull,
    nibBPull,
    nibBWake,
    nibBRd,
    pairAWe,
    pairAWd,
    pairACfgWe,
    pairAPushPull,
    pairAPull,
    pairAWake,
    pairARd,
    pairBWe,
    pairBWd,
    pairBCfgWe,
    pairBPushPull,
    pairBRd,
    serDataOutEn,
    serDataOut,
    serClockOutEn,
    serClockOut,
    serDataIn,
    serClockIn,
    cntOneOutEn,
    cntOneOut,
    cntZeroOutEn,
    cntZeroOut,
    cntOneIn,
    cntZeroIn,
    extIrqIn,
    analogSamplePins,
    wakeupReq,
    sixBitPinIn,
    sixBitPinOut,
    sixBitPinOe_b,
    sixBitPullOn,
    nibAPinIn,
    nibAPinOut,
    nibAPinOe_b,
    nibAPullOn,
    nibBPinIn,
    nibBPinOut,
    nibBPinOe_b,
    nibBPullOn,
    pairAPinIn,
    pairAPinOut,
    pairAPinOe_b,
    pairAPullOn,
    pairBPinIn,
    pairBPinOut,
    pairBPinOe_b
);
    input wire clk;
    input wire rst_b;
    input wire swResetReq;
    input wire wdtResetReq;
    input wire vdropResetReq;
    input wire porResetReq;
    output wire resetPinOut;
    output wire resetPinOe_b;
    input wire sixBitSetStb;
    input wire sixBitClrStb;
    input wire [2:0] sixBitSel;
    input wire sixBitCfgWe;
    input wire [SIX_W-1:0] sixBitPushPull;
    input wire [SIX_W-1:0] sixBitPull;
    input wire [SIX_W-1:0] sixBitWake;
    output reg sixBitSkip;
    input wire nibAWe;
    input wire [NIB_W-1:0] nibAWd;
    input wire nibACfgWe;
    input wire [NIB_W-1:0] nibAPushPull;
    input wire [NIB_W-1:0] nibAPull;
    input wire [NIB_W-1:0] nibAWake;
    output reg [NIB_W-1:0] nibARd;
    input wire nibBWe;
    input wire [NIB_W-1:0] nibBWd;
    input wire nibBCfgWe;
    input wire [NIB_W-1:0] nibBPushPull;
    input wire [NIB_W-1:0] nibBPull;
    input wire [NIB_W-1:0] nibBWake;
    output reg [NIB_W-1:0] nibBRd;
    input wire pairAWe;
    input wire [PAIR_W-1:0] pairAWd;
    input wire pairACfgWe;
    input wire [PAIR_W-1:0] pairAPushPull;
    input wire [PAIR_W-1:0] pairAPull;
    input wire [PAIR_W-1:0] pairAWake;
    output reg [PAIR_W-1:0] pairARd;
    input wire pairBWe;
    input wire [PAIR_W-1:0] pairBWd;
    input wire pairBCfgWe;
    input wire [PAIR_W-1:0] pairBPushPull;
    output reg [PAIR_W-1:0] pairBRd;
    input wire serDataOutEn;
    input wire serDataOut;
    input wire serClockOutEn;
    input wire serClockOut;
    output wire serDataIn;
    output wire serClockIn;
    input wire cntOneOutEn;
    input wire cntOneOut;
    input wire cntZeroOutEn;
    input wire cntZeroOut;
    output wire cntOneIn;
    output wire cntZeroIn;
    output wire extIrqIn;
    output wire [`GPPS_AN_W-1:0] analogSamplePins;
    output reg wakeupReq;
    input wire [SIX_W-1:0] sixBitPinIn;
    output wire [SIX_W-1:0] sixBitPinOut;
    output wire [SIX_W-1:0] sixBitPinOe_b;
    output wire [SIX_W-1:0] sixBitPullOn;
    input wire [NIB_W-1:0] nibAPinIn;
    output wire [NIB_W-1:0] nibAPinOut;
    output wire [NIB_W-1:0] nibAPinOe_b;
    output wire [NIB_W-1:0] nibAPullOn;
    input wire [NIB_W-1:0] nibBPinIn;
    output wire [NIB_W-1:0] nibBPinOut;
    output wire [NIB_W-1:0] nibBPinOe_b;
    output wire [NIB_W-1:0] nibBPullOn;
    input wire [PAIR_W-1:0] pairAPinIn;
    output wire [PAIR_W-1:0] pairAPinOut;
    output wire [PAIR_W-1:0] pairAPinOe_b;
    output wire [PAIR_W-1:0] pairAPullOn;
    input wire [PAIR_W-1:0] pairBPinIn;
    output wire [PAIR_W-1:0] pairBPinOut;
    output wire [PAIR_W-1:0] pairBPinOe_b;

    wire rstSync_b;
    wire [SIX_W-1:0] sixWakeHit;
    wire [NIB_W-1:0] nibAWakeHit;
    wire [NIB_W-1:0] nibBWakeHit;
    wire [PAIR_W-1:0] pairAWakeHit;
    wire [NIB_W-1:0] nibAAltEn;
    wire [NIB_W-1:0] nibAAltOut;
    wire [NIB_W-1:0] nibBAltEn;
    wire [NIB_W-1:0] nibBAltOut;

    ////////////////////////////////////////////////////////////////////////
    gpps_reset_pin uRst (
        .clk(clk),
        .rst_b(rst_b),
        .swResetReq(swResetReq),
        .wdtResetReq(wdtResetReq),
        .vdropResetReq(vdropResetReq),
        .porResetReq(porResetReq),
        .rstSync_b(rstSync_b),
        .resetPinOut(resetPinOut),
        .resetPinOe_b(resetPinOe_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // alternate outputs; serial input, counter input and irq use no driver
    assign nibAAltEn = {1'b0, serClockOutEn, serDataOutEn, 1'b0};
    assign nibAAltOut = {1'b1, serClockOut, serDataOut, 1'b1};
    assign nibBAltEn = {1'b0, cntZeroOutEn, cntOneOutEn, 1'b0};
    assign nibBAltOut = {1'b1, cntZeroOut, cntOneOut, 1'b1};

    // alternate inputs tapped straight from the pins
    assign serDataIn = nibAPinIn[`GPPS_SER_IN_BIT];
    assign serClockIn = nibAPinIn[`GPPS_SER_CLK_BIT];
    assign cntOneIn = nibBPinIn[`GPPS_CNT1_BIT];
    assign cntZeroIn = nibBPinIn[`GPPS_CNT0_BIT];
    assign extIrqIn = nibBPinIn[`GPPS_IRQ_BIT];
    assign analogSamplePins = {sixBitPinIn[`GPPS_SIX_KEY_HI],
        sixBitPinIn[`GPPS_SIX_KEY_LO], pairBPinIn, pairAPinIn};

    ////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < SIX_W; i = i + 1) begin : gSix
            gpps_pin_cell #(
                .HAS_PULL((i == `GPPS_SIX_KEY_LO) || (i == `GPPS_SIX_KEY_HI))
            ) uCell (
                .clk(clk),
                .rstSync_b(rstSync_b),
                .latchWe((sixBitSetStb | sixBitClrStb) &&
                    (sixBitSel == i)),
                .latchWd(sixBitSetStb),
                .cfgWe(sixBitCfgWe),
                .pushPullWd(sixBitPushPull[i]),
                .pullWd(sixBitPull[i]),
                .wakeWd(sixBitWake[i]),
                .altOutEn(1'b0),
                .altOut(1'b1),
                .pinIn(sixBitPinIn[i]),
                .pinOut(sixBitPinOut[i]),
                .pinOe_b(sixBitPinOe_b[i]),
                .pullOn(sixBitPullOn[i]),
                .wakeEn(),
                .wakeHit(sixWakeHit[i])
            );
        end
        for (i = 0; i < NIB_W; i = i + 1) begin : gNib
            gpps_pin_cell #(.HAS_PULL(1)) uA (
                .clk(clk),
                .rstSync_b(rstSync_b),
                .latchWe(nibAWe),
                .latchWd(nibAWd[i]),
                .cfgWe(nibACfgWe),
                .pushPullWd(nibAPushPull[i]),
                .pullWd(nibAPull[i]),
                .wakeWd(nibAWake[i]),
                .altOutEn(nibAAltEn[i]),
                .altOut(nibAAltOut[i]),
                .pinIn(nibAPinIn[i]),
                .pinOut(nibAPinOut[i]),
                .pinOe_b(nibAPinOe_b[i]),
                .pullOn(nibAPullOn[i]),
                .wakeEn(),
                .wakeHit(nibAWakeHit[i])
            );
            gpps_pin_cell #(.HAS_PULL(1)) uB (
                .clk(clk),
                .rstSync_b(rstSync_b),
                .latchWe(nibBWe),
                .latchWd(nibBWd[i]),
                .cfgWe(nibBCfgWe),
                .pushPullWd(nibBPushPull[i]),
                .pullWd(nibBPull[i]),
                .wakeWd(nibBWake[i]),
                .altOutEn(nibBAltEn[i]),
                .altOut(nibBAltOut[i]),
                .pinIn(nibBPinIn[i]),
                .pinOut(nibBPinOut[i]),
                .pinOe_b(nibBPinOe_b[i]),
                .pullOn(nibBPullOn[i]),
                .wakeEn(),
                .wakeHit(nibBWakeHit[i])
            );
        end
        for (i = 0; i < PAIR_W; i = i + 1) begin : gPair
            gpps_pin_cell #(.HAS_PULL(1)) uA (
                .clk(clk),
                .rstSync_b(rstSync_b),
                .latchWe(pairAWe),
                .latchWd(pairAWd[i]),
                .cfgWe(pairACfgWe),
                .pushPullWd(pairAPushPull[i]),
                .pullWd(pairAPull[i]),
                .wakeWd(pairAWake[i]),
                .altOutEn(1'b0),
                .altOut(1'b1),
                .pinIn(pairAPinIn[i]),
                .pinOut(pairAPinOut[i]),
                .pinOe_b(pairAPinOe_b[i]),
                .pullOn(pairAPullOn[i]),
                .wakeEn(),
                .wakeHit(pairAWakeHit[i])
            );
            gpps_pin_cell #(.HAS_PULL(0)) uB (
                .clk(clk),
                .rstSync_b(rstSync_b),
                .latchWe(pairBWe),
                .latchWd(pairBWd[i]),
                .cfgWe(pairBCfgWe),
                .pushPullWd(pairBPushPull[i]),
                .pullWd(1'b0),
                .wakeWd(1'b0),
                .altOutEn(1'b0),
                .altOut(1'b1),
                .pinIn(pairBPinIn[i]),
                .pinOut(pairBPinOut[i]),
                .pinOe_b(pairBPinOe_b[i]),
                .pullOn(),
                .wakeEn(),
                .wakeHit()
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // registered pin reads, skip decision and wakeup request
    always @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            sixBitSkip <= 1'b0;
            nibARd <= {NIB_W{1'b0}};
            nibBRd <= {NIB_W{1'b0}};
            pairARd <= {PAIR_W{1'b0}};
            pairBRd <= {PAIR_W{1'b0}};
            wakeupReq <= 1'b0;
        end else begin
            sixBitSkip <= (sixBitSel < SIX_W) ?
                sixBitPinIn[sixBitSel] : 1'b0;
            nibARd <= nibAPinIn;
            nibBRd <= nibBPinIn;
            pairARd <= pairAPinIn;
            pairBRd <= pairBPinIn;
            wakeupReq <= |{sixWakeHit, nibAWakeHit, nibBWakeHit,
                pairAWakeHit};
        end
    end
endmodule

// [gpps_monitor.sv]
// port assertions for the shared-pin port block
`timescale 1ns/1ps
module gpps_monitor #(
    parameter SIX_W = 6,
    parameter NIB_W = 4,
    parameter PAIR_W = 2
) (
    input wire clk,
    input wire rst_b,
    input wire swResetReq,
    input wire wdtResetReq,
    input wire vdropResetReq,
    input wire porResetReq,
    input wire resetPinOut,
    input wire resetPinOe_b,
    input wire sixBitSetStb,
    input wire sixBitClrStb,
    input wire [2:0] sixBitSel,
    input wire sixBitSkip,
    input wire [SIX_W-1:0] sixBitPinIn,
    input wire [SIX_W-1:0] sixBitPinOut,
    input wire [SIX_W-1:0] sixBitPinOe_b,
    input wire nibAWe,
    input wire [NIB_W-1:0] nibAWd,
    input wire [NIB_W-1:0] nibAPinIn,
    input wire [NIB_W-1:0] nibAPinOut,
    input wire [NIB_W-1:0] nibAPinOe_b,
    input wire [NIB_W-1:0] nibARd,
    input wire [NIB_W-1:0] nibBPinIn,
    input wire [NIB_W-1:0] nibBPinOe_b,
    input wire [PAIR_W-1:0] pairAPinIn,
    input wire [PAIR_W-1:0] pairBPinIn,
    input wire serDataIn,
    input wire serClockIn,
    input wire cntOneIn,
    input wire cntZeroIn,
    input wire extIrqIn,
    input wire [5:0] analogSamplePins,
    input wire wakeupReq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
////////////////////////////////////////////////////////////////
    reset_pin_low_a: assert property (
        (swResetReq || wdtResetReq || vdropResetReq || porResetReq)
        |-> !resetPinOe_b && !resetPinOut)
        else $error("reset pin not driven low");
    reset_state_a: assert property (
        $rose(rst_b) |-> !resetPinOe_b && (&sixBitPinOe_b)
        && (&nibAPinOe_b) && (&nibBPinOe_b))
        else $error("pins driven right after reset");
    six_set_a: assert property (
        sixBitSetStb && sixBitSel < 3'h6 && resetPinOe_b |=> sixBitPinOut
        == ($past(sixBitPinOut) | (6'h01 << $past(sixBitSel))))
        else $error("six-bit set touched wrong bits");
    six_clr_a: assert property (
        sixBitClrStb && !sixBitSetStb && sixBitSel < 3'h6 && resetPinOe_b
        |=> sixBitPinOut
        == ($past(sixBitPinOut) & ~(6'h01 << $past(sixBitSel))))
        else $error("six-bit clear touched wrong bits");
    skip_read_a: assert property (
        resetPinOe_b && $past(resetPinOe_b) |-> {5'h0, sixBitSkip}
        == (($past(sixBitPinIn) >> $past(sixBitSel)) & 6'h01))
        else $error("skip bit not the selected pin");
    nib_write_a: assert property (
        nibAWe && resetPinOe_b
        |=> (nibAPinOut & 4'h9) == ($past(nibAWd) & 4'h9))
        else $error("nibble latch write lost");
    nib_read_a: assert property (
        resetPinOe_b && $past(resetPinOe_b) |-> nibARd == $past(nibAPinIn))
        else $error("nibble read not last pin level");
    alt_input_map_a: assert property (
        serDataIn == nibAPinIn[0] && serClockIn == nibAPinIn[2]
        && cntOneIn == nibBPinIn[1] && cntZeroIn == nibBPinIn[2]
        && extIrqIn == nibBPinIn[3])
        else $error("shared input pin mapping wrong");
    analog_map_a: assert property (
        analogSamplePins == {sixBitPinIn[3:2], pairBPinIn, pairAPinIn})
        else $error("analog pin mapping wrong");
    cover property (sixBitSkip);
    cover property (wakeupReq);
    cover property (wdtResetReq && !resetPinOe_b);
endmodule
bind gpps_top gpps_monitor #(.SIX_W(SIX_W), .NIB_W(NIB_W),
    .PAIR_W(PAIR_W)) mon (.*);

// [gpps_pin_model.sv]
// outside circuit on a group of port pins
`timescale 1ns/1ps
module gpps_pin_model #(
    parameter W = 4
) (
    input wire clk,
    input wire [W-1:0] lvl,
    input wire [W-1:0] oe_b,
    input wire [W-1:0] pu,
    input wire [W-1:0] xEn,
    input wire [W-1:0] xVal,
    output wire [W-1:0] pin
);
    reg [W-1:0] last_ff = '0;
    // undriven unpulled bits flip every cycle, never a stale match
    assign pin = (~oe_b & lvl) | (oe_b & xEn & xVal)
        | (oe_b & ~xEn & (pu | ~last_ff));
    always @(posedge clk) last_ff <= pin;
endmodule

// [tb_gpps_top.sv]
// self-checking bench for the shared-pin port block
`timescale 1ns/1ps
module tb_gpps_top;
    logic clk = '0, rst_b = '0;
    logic swResetReq = '0, wdtResetReq = '0;
    logic vdropResetReq = '0, porResetReq = '0;
    logic sixBitSetStb = '0, sixBitClrStb = '0, sixBitCfgWe = '0;
    logic [2:0] sixBitSel = '0;
    logic [5:0] sixBitPushPull = '0, sixBitPull = '0, sixBitWake = '0;
    logic nibAWe = '0, nibACfgWe = '0, nibBWe = '0, nibBCfgWe = '0;
    logic [3:0] nibAWd = '0, nibAPushPull = '0, nibAPull = '0;
    logic [3:0] nibBWd = '0, nibBPushPull = '0, nibBPull = '0;
    logic [3:0] nibAWake = '0, nibBWake = '0;
    logic pairAWe = '0, pairACfgWe = '0, pairBWe = '0, pairBCfgWe = '0;
    logic [1:0] pairAWd = '0, pairAPushPull = '0, pairAPull = '0;
    logic [1:0] pairAWake = '0, pairBWd = '0, pairBPushPull = '0;
    logic serDataOutEn = '0, serDataOut = '0;
    logic serClockOutEn = '0, serClockOut = '0;
    logic cntOneOutEn = '0, cntOneOut = '0;
    logic cntZeroOutEn = '0, cntZeroOut = '0;
    logic resetPinOut, resetPinOe_b, sixBitSkip, serDataIn, serClockIn;
    logic cntOneIn, cntZeroIn, extIrqIn, wakeupReq;
    logic [5:0] analogSamplePins, sixBitPinIn, sixBitPinOut;
    logic [5:0] sixBitPinOe_b, sixBitPullOn;
    logic [3:0] nibARd, nibAPinIn, nibAPinOut, nibAPinOe_b, nibAPullOn;
    logic [3:0] nibBRd, nibBPinIn, nibBPinOut, nibBPinOe_b, nibBPullOn;
    logic [1:0] pairARd, pairAPinIn, pairAPinOut, pairAPinOe_b;
    logic [1:0] pairAPullOn, pairBRd, pairBPinIn, pairBPinOut;
    logic [1:0] pairBPinOe_b;
    // outside drive: six [17:12], nibA [11:8], nibB [7:4], pairs [3:0]
    logic [17:0] extEn = '0, extVal = '0;
    logic [1:0] pairBExtPu = '0;
    int fail_count = 0, samples_checked = 0, cycles = 0;

    gpps_top DUT (.*);
    gpps_pin_model #(.W(6)) sixM (.clk(clk), .lvl(sixBitPinOut),
        .oe_b(sixBitPinOe_b), .pu(sixBitPullOn), .xEn(extEn[17:12]),
        .xVal(extVal[17:12]), .pin(sixBitPinIn));
    gpps_pin_model #(.W(4)) nibAM (.clk(clk), .lvl(nibAPinOut),
        .oe_b(nibAPinOe_b), .pu(nibAPullOn), .xEn(extEn[11:8]),
        .xVal(extVal[11:8]), .pin(nibAPinIn));
    gpps_pin_model #(.W(4)) nibBM (.clk(clk), .lvl(nibBPinOut),
        .oe_b(nibBPinOe_b), .pu(nibBPullOn), .xEn(extEn[7:4]),
        .xVal(extVal[7:4]), .pin(nibBPinIn));
    gpps_pin_model #(.W(2)) pairAM (.clk(clk), .lvl(pairAPinOut),
        .oe_b(pairAPinOe_b), .pu(pairAPullOn), .xEn(extEn[3:2]),
        .xVal(extVal[3:2]), .pin(pairAPinIn));
    gpps_pin_model #(.W(2)) pairBM (.clk(clk), .lvl(pairBPinOut),
        .oe_b(pairBPinOe_b), .pu(pairBExtPu), .xEn(extEn[1:0]),
        .xVal(extVal[1:0]), .pin(pairBPinIn));

    always #5 clk = ~clk;
////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic [5:0] pp, pu, wk);
        @(posedge clk);
        {sixBitCfgWe, nibACfgWe, nibBCfgWe, pairACfgWe, pairBCfgWe} <= '1;
        {sixBitPushPull, sixBitPull, sixBitWake} <= {pp, pu, wk};
        {nibAPushPull, nibAPull, nibAWake} <= {pp[3:0], pu[3:0], wk[3:0]};
        {nibBPushPull, nibBPull, nibBWake} <= {pp[3:0], pu[3:0], wk[3:0]};
        {pairAPushPull, pairAPull, pairAWake} <= {pp[1:0], pu[1:0], wk[1:0]};
        pairBPushPull <= pp[1:0];
        @(posedge clk);
        {sixBitCfgWe, nibACfgWe, nibBCfgWe, pairACfgWe, pairBCfgWe} <= '0;
    endtask
    task automatic wr(input logic [3:0] v);
        @(posedge clk);
        {nibAWe, nibBWe, pairAWe, pairBWe} <= 4'hf;
        {nibAWd, nibBWd, pairAWd, pairBWd} <= {v, v, v[1:0], v[1:0]};
        @(posedge clk);
        {nibAWe, nibBWe, pairAWe, pairBWe} <= 4'h0;
    endtask
    task automatic six(input logic s, c, input logic [2:0] b);
        @(posedge clk);
        {sixBitSel, sixBitSetStb, sixBitClrStb} <= {b, s, c};
        @(posedge clk);
        {sixBitSetStb, sixBitClrStb} <= 2'h0;
        @(negedge clk);
    endtask
////////////////////////////////////////////////////////////////
    task automatic t_reset;
        @(negedge clk);
        chk({sixBitPinOe_b, &nibAPinOe_b, &nibBPinOe_b}, 8'hff);
        chk({sixBitPinOut, &pairAPinOe_b, &pairBPinOe_b}, 8'hff);
        chk({|sixBitPullOn, |nibAPullOn, |nibBPullOn, |pairAPullOn},
            '0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {porResetReq, vdropResetReq, wdtResetReq, swResetReq} <= 4'h1 << i;
            @(negedge clk);
            chk({resetPinOut, resetPinOe_b}, '0);
            @(posedge clk);
            {porResetReq, vdropResetReq, wdtResetReq, swResetReq} <= 4'h0;
            repeat (4) @(negedge clk);
            chk(resetPinOe_b, 8'h01);
        end
        $display("reset test done");
    endtask
    task automatic t_six;
        logic [5:0] exp;
        exp = 6'h3f;
        cfg(6'h3f, '0, '0);
        for (int i = 0; i < 6; i++) begin
            six(1'b0, 1'b1, i[2:0]);
            exp[i] = 1'b0;
            chk(sixBitPinOut, exp);
            chk(sixBitPinOe_b, '0);
        end
        six(1'b1, 1'b1, 3'h4);
        exp[4] = 1'b1;
        chk(sixBitPinOut, exp);
        $display("six-bit test done");
    endtask
    task automatic t_nib;
        logic [6:0] pat;
        pat = 7'h2d;
        cfg(6'h3f, '0, '0);
        wr(4'h5);
        @(negedge clk);
        chk({nibAPinOut, nibBPinOut}, 8'h55);
        chk({pairAPinOut, pairBPinOut, nibAPinOe_b}, 8'h50);
        cfg('0, '0, '0);
        @(negedge clk);
        chk({nibAPinOe_b, nibBPinOe_b}, 8'h55);
        chk({pairAPinOe_b, pairBPinOe_b}, 8'h05);
        wr(4'hf);
        for (int i = 0; i < 6; i++) six(1'b1, 1'b0, i[2:0]);
        @(posedge clk);
        extEn <= '1;
        extVal <= {6'h2d, 4'h5, 4'ha, 2'h2, 2'h1};
        repeat (2) @(negedge clk);
        chk({nibARd, nibBRd}, 8'h5a);
        chk({pairARd, pairBRd}, 8'h09);
        chk({serDataIn, serClockIn, cntOneIn, cntZeroIn, extIrqIn},
            8'h1d);
        chk(analogSamplePins, 8'h36);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            sixBitSel <= i[2:0];
            @(posedge clk);
            @(negedge clk);
            chk(sixBitSkip, pat[i]);
        end
        $display("port read test done");
    endtask
    task automatic t_share;
        @(posedge clk);
        extEn <= '0;
        {serDataOutEn, serClockOutEn, cntOneOutEn, cntZeroOutEn} <= 4'hf;
        cfg(6'h3f, '0, '0);
        repeat (2) @(negedge clk);
        chk({nibAPinOut, nibBPinOut}, 8'h99);
        chk({nibARd, nibBRd}, 8'h99);
        @(posedge clk);
        {serDataOut, serClockOut, cntOneOut, cntZeroOut} <= 4'hf;
        repeat (2) @(negedge clk);
        chk({nibARd, nibBRd}, 8'hff);
        wr(4'h6);
        repeat (2) @(negedge clk);
        chk({nibARd, nibBRd}, 8'h66);
        $display("shared pin test done");
    endtask
    task automatic t_pull;
        @(posedge clk);
        {serDataOutEn, serClockOutEn, cntOneOutEn, cntZeroOutEn} <= 4'h0;
        pairBExtPu <= 2'h3;
        wr(4'hf);
        cfg('0, 6'h3f, '0);
        repeat (2) @(negedge clk);
        chk(sixBitPullOn, 8'h0c);
        chk({nibAPullOn, nibBPullOn}, 8'hff);
        chk({pairAPullOn, wakeupReq}, 8'h06);
        chk({nibARd, nibBRd}, 8'hff);
        chk({pairARd, pairBRd}, 8'h0f);
        @(posedge clk);
        extEn[7] <= 1'b1;
        extVal[7] <= 1'b0;
        cfg('0, 6'h3f, 6'h3f);
        repeat (2) @(negedge clk);
        chk(wakeupReq, 8'h01);
        cfg('0, 6'h3f, 6'h37);
        repeat (2) @(negedge clk);
        chk(wakeupReq, '0);
        @(posedge clk);
        extEn[14] <= 1'b1;
        extVal[14] <= 1'b0;
        repeat (2) @(negedge clk);
        chk(wakeupReq, 8'h01);
        $display("pull and wakeup test done");
    endtask
////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            finish_test;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_six;
        t_nib;
        t_share;
        t_pull;
        finish_test;
    end
endmodule
